/* File: dv/channel_diag_record_asserts.sv */
/* Checker for the channel diagnostic record ports.
   Assumes it is bound into channel_diag_record. */
`timescale 1ns/1ps
`default_nettype none
module channel_diag_record_asserts #(
  parameter int NUM_CH = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [4:0] rd_index,
  input wire logic [7:0] rd_data_q,
  input wire logic [NUM_CH-1:0] chan_led_q,
  input wire logic [7:0] module_diag_q,
  input wire logic [31:0] ticker_q,
  input wire logic event_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // Record bytes
  // ****
  chk_bits_const: assert property (rd_index == 5'h07 |=> rd_data_q == 8'h08)
    else $error("bits byte wrong");
  chk_count_const: assert property (rd_index == 5'h08 |=> rd_data_q == 8'h04)
    else $error("count byte wrong");
  chk_summary_led: assert property (rd_index == 5'h09 |=> rd_data_q == {4'h0, $past(chan_led_q)})
    else $error("summary byte wrong");
  chk_chan_rsvd: assert property (rd_index inside {[5'h0a:5'h0d]} |=> (rd_data_q & 8'hf6) == 8'h00)
    else $error("channel byte reserved bits");
  chk_unused_zero: assert property (rd_index inside {[5'h0e:5'h11]} |=> rd_data_q == 8'h00)
    else $error("unused byte not zero");
  chk_unmapped_zero: assert property ((rd_index <= 5'h06 || rd_index >= 5'h16) |=> rd_data_q == 8'h00)
    else $error("unmapped byte not zero");
  // ****
  // Status, event and ticker
  // ****
  chk_module_any: assert property (module_diag_q == {4'h0, |chan_led_q, 3'h0})
    else $error("module byte wrong");
  chk_event_led: assert property ($rose(|chan_led_q) |-> event_q && chan_led_q != 4'h0)
    else $error("no event on error");
  chk_tick_step: assert property ($changed(ticker_q) |-> ticker_q == $past(ticker_q) + 32'h0000_0001)
    else $error("ticker step");
  chk_tick_period: assert property ($changed(ticker_q) |-> ##100 $changed(ticker_q))
    else $error("ticker period");
endmodule : channel_diag_record_asserts
bind channel_diag_record channel_diag_record_asserts #(.NUM_CH(NUM_CH)) u_chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .rd_index(rd_index), .rd_data_q(rd_data_q), .chan_led_q(chan_led_q),
  .module_diag_q(module_diag_q), .ticker_q(ticker_q), .event_q(event_q));
`default_nettype wire

/* File: dv/channel_diag_record_bench.sv */
/* Bench for the channel diagnostic record: reads, faults, ticker.
   Assumes package, design and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module channel_diag_record_bench;
  logic sys_clk, reset_n, event_q;
  diag_record_pkg::chan_fault_s [3:0] fault_in;
  logic [4:0] rd_index;
  logic [7:0] rd_data_q, module_diag_q;
  logic [3:0] chan_led_q;
  logic [31:0] ticker_q, stamp, t0;
  int mismatches, check_count, cyc;
  channel_diag_record dut (.sys_clk(sys_clk), .reset_n(reset_n), .fault_in(fault_in), .rd_index(rd_index),
    .rd_data_q(rd_data_q), .chan_led_q(chan_led_q), .module_diag_q(module_diag_q), .ticker_q(ticker_q),
    .event_q(event_q));
  // ****
  // Clock, timeout and helpers
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Byte read: index set at one falling edge, data seen at the next
  task automatic rd(input logic [4:0] idx, input logic [7:0] exp);
    @(negedge sys_clk) rd_index = idx;
    @(negedge sys_clk) cmp("record byte", 32'(exp), 32'(rd_data_q));
  endtask : rd
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // ****
  // Tests
  // ****
  initial begin
    reset_n = 1'b0;
    fault_in = '0;
    rd_index = 5'h00;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    cmp("ticker", 32'h0000_0000, ticker_q);
    rd(5'h07, 8'h08);
    rd(5'h08, 8'h04);
    for (int i = 9; i <= 17; i++) rd(5'(i), 8'h00);
    rd(5'h03, 8'h00);
    rd(5'h16, 8'h00);
    rd(5'h1f, 8'h00);
    $display("test constants done");
    for (int c = 0; c < 4; c++) begin
      fault_in[c].param_err = 1'b1;
      repeat (10) @(negedge sys_clk);
      cmp("led", 32'h0000_0001 << c, 32'(chan_led_q));
      cmp("module", 32'h0000_0008, 32'(module_diag_q));
      rd(5'h09, 8'h01 << c);
      rd(5'(10 + c), 8'h01);
      fault_in[c].short_gnd = 1'b1;
      repeat (10) @(negedge sys_clk);
      rd(5'(10 + c), 8'h09);
      fault_in[c] = '0;
      repeat (10) @(negedge sys_clk);
      rd(5'(10 + c), 8'h00);
    end
    cmp("module", 32'h0000_0000, 32'(module_diag_q));
    $display("test channels done");
    t0 = ticker_q;
    for (int n = 0; n < 110 && ticker_q === t0; n++) @(negedge sys_clk);
    t0 = ticker_q;
    repeat (100) @(negedge sys_clk);
    cmp("ticker step", t0 + 32'h0000_0001, ticker_q);
    fault_in[1].param_err = 1'b1;
    fault_in[3].short_gnd = 1'b1;
    for (int n = 0; n < 20 && event_q !== 1'b1; n++) @(negedge sys_clk);
    cmp("event", 32'h0000_0001, 32'(event_q));
    rd(5'h09, 8'h0a);
    for (int b = 0; b < 4; b++) begin
      @(negedge sys_clk) rd_index = 5'(18 + b);
      @(negedge sys_clk) stamp[8*b +: 8] = rd_data_q;
    end
    cmp("stamp", t0 + 32'h0000_0001, stamp);
    $display("test stamp done");
    fault_in = '0;
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    cmp("ticker", 32'h0000_0000, ticker_q);
    rd(5'h12, 8'h00);
    $display("test reset done");
    final_report();
  end
endmodule : channel_diag_record_bench
`default_nettype wire

/* File: logic/channel_diag_record.sv */
/*
  Channel part of the diagnostic record of a four-channel analog output module,
  with the microsecond ticker and event timestamp.
  Assumes fault inputs arrive asynchronously from channel monitors; the record
  is read one byte at a time by the host side through rd_index/rd_data.
  Read index casts assume four channels; a wider NUM_CH needs wider casts.
*/
`timescale 1ns/1ps
`default_nettype none
module channel_diag_record #(
  parameter int NUM_CH = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire diag_record_pkg::chan_fault_s [NUM_CH-1:0] fault_in,
  input wire logic [4:0] rd_index,
  output logic [7:0] rd_data_q,
  output logic [NUM_CH-1:0] chan_led_q,
  output logic [7:0] module_diag_q,
  output logic [31:0] ticker_q,
  output logic event_q
);
  // ************************************************************
  // Ticker
  // ************************************************************
  // Runs from reset and never stops; the record only copies its count,
  // so a host read can never disturb the timebase
  logic [31:0] ticks;
  us_ticker #(
    .WIDTH(32)
  ) u_ticker (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .ticks_q(ticks)
  );

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [2*NUM_CH-1:0] raw;
  logic [2*NUM_CH-1:0] s1_q;
  logic [2*NUM_CH-1:0] s2_q;
  logic [2*NUM_CH-1:0] s3_q;
  logic [2*NUM_CH-1:0] flt_q;
  logic [7:0] ch_err_q [NUM_CH];
  logic [NUM_CH-1:0] any_ch;
  logic [7:0] summary_q;
  logic [31:0] stamp_q;
  logic [NUM_CH-1:0] any_prev_q;
  logic new_err;

  // ************************************************************
  // Helper functions
  // ************************************************************
  // True when idx lies within first..last, both ends included
  function automatic logic index_in(input logic [4:0] idx, input logic [4:0] first,
                                    input logic [4:0] last);
    return (idx >= first) && (idx <= last);
  endfunction : index_in

  // Builds one channel error byte from its two filtered fault levels
  // Reserved bits start low here, so no other path can ever set them
  function automatic logic [7:0] chan_byte(input logic param_err, input logic short_gnd);
    logic [7:0] b;
    b = diag_record_pkg::RESET_BYTE;
    b[diag_record_pkg::CH_ERR_PARAM_BIT] = param_err;
    b[diag_record_pkg::CH_ERR_SHORT_BIT] = short_gnd;
    return b;
  endfunction : chan_byte

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_raw
      assign raw[2*g] = fault_in[g].param_err;
      assign raw[2*g+1] = fault_in[g].short_gnd;
      assign any_ch[g] = ch_err_q[g][diag_record_pkg::CH_ERR_PARAM_BIT] |
                         ch_err_q[g][diag_record_pkg::CH_ERR_SHORT_BIT];
    end
  endgenerate

  // Three-stage capture of asynchronous fault levels
  // Only stage two reads stage one, so a metastable first stage has a cycle to settle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered level updates only when stages two and three agree
  // A one-cycle flicker on a fault pin therefore never reaches the record
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flt_q <= '0;
    end else begin
      flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
    end
  end

  // ************************************************************
  // Channel error bytes and summary
  // ************************************************************
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // Per-channel error byte, reserved bits held zero
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          ch_err_q[g] <= diag_record_pkg::RESET_BYTE;
        end else begin
          ch_err_q[g] <= chan_byte(flt_q[2*g], flt_q[2*g+1]);
        end
      end
    end
  endgenerate

  // Summary byte: bit n follows channel n, upper bits stay zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      summary_q <= diag_record_pkg::RESET_BYTE;
    end else begin
      summary_q <= 8'(any_ch);
    end
  end

  // Module diagnostic byte: only the channel-error bit is owned here
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      module_diag_q <= diag_record_pkg::RESET_BYTE;
    end else begin
      module_diag_q <= diag_record_pkg::RESET_BYTE;
      module_diag_q[diag_record_pkg::MODULE_CHANNEL_ERROR_BIT] <= |any_ch;
    end
  end

  // Channel indicators follow the same error state as the record
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      chan_led_q <= '0;
    end else begin
      chan_led_q <= any_ch;
    end
  end

  // ************************************************************
  // Event detection and timestamp
  // ************************************************************
  // A channel going from no error to error is a diagnostic event
  assign new_err = |(any_ch & ~any_prev_q);

  // Previous error state and the one-cycle event pulse
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      any_prev_q <= '0;
      event_q <= 1'b0;
    end else begin
      any_prev_q <= any_ch;
      event_q <= new_err;
    end
  end

  // Timestamp keeps the ticker value of the latest event until the next one
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stamp_q <= diag_record_pkg::RESET_TICKER;
    end else if (new_err) begin
      stamp_q <= ticks;
    end
  end

  // Ticker output copy
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ticker_q <= diag_record_pkg::RESET_TICKER;
    end else begin
      ticker_q <= ticks;
    end
  end

  // ************************************************************
  // Record read port
  // ************************************************************
  // Registered byte selection; unmapped and reserved bytes read zero
  // Data lag the index by one clock, so a host may step the index every cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_data_q <= diag_record_pkg::RESET_BYTE;
    end else begin
      if (rd_index == diag_record_pkg::IDX_DIAG_BITS_PER_CHANNEL) begin
        rd_data_q <= diag_record_pkg::DIAG_BITS_PER_CHANNEL;
      end else if (rd_index == diag_record_pkg::IDX_CHANNEL_COUNT) begin
        rd_data_q <= diag_record_pkg::CHANNEL_COUNT;
      end else if (rd_index == diag_record_pkg::IDX_CHANNEL_GROUP_ERROR_SUMMARY) begin
        rd_data_q <= summary_q;
      end else if (index_in(rd_index, diag_record_pkg::IDX_PER_CHANNEL_ERROR_FIRST,
                            diag_record_pkg::IDX_PER_CHANNEL_ERROR_LAST)) begin
        rd_data_q <= ch_err_q[2'(rd_index - diag_record_pkg::IDX_PER_CHANNEL_ERROR_FIRST)];
      end else if (index_in(rd_index, diag_record_pkg::IDX_UNUSED_CHANNEL_ERROR_FIRST,
                            diag_record_pkg::IDX_UNUSED_CHANNEL_ERROR_LAST)) begin
        rd_data_q <= diag_record_pkg::RESET_BYTE;
      end else if (index_in(rd_index, diag_record_pkg::IDX_DIAG_TIMESTAMP,
                            diag_record_pkg::IDX_DIAG_TIMESTAMP_LAST)) begin
        rd_data_q <= stamp_q[8*(2'(rd_index - diag_record_pkg::IDX_DIAG_TIMESTAMP)) +: 8];
      end else begin
        rd_data_q <= 8'h00;
      end
    end
  end
endmodule : channel_diag_record
`default_nettype wire

/* File: logic/diag_record_pkg.sv */
/*
  Package for the channel diagnostic record: record byte indices, constants,
  field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a byte-wide read port into the record.
*/
`default_nettype none
package diag_record_pkg;
  // ************************************************************
  // Record layout (byte index within the latter record part)
  // ************************************************************
  localparam logic [4:0] IDX_DIAG_BITS_PER_CHANNEL = 5'h07;
  localparam logic [4:0] IDX_CHANNEL_COUNT = 5'h08;
  localparam logic [4:0] IDX_CHANNEL_GROUP_ERROR_SUMMARY = 5'h09;
  localparam logic [4:0] IDX_PER_CHANNEL_ERROR_FIRST = 5'h0a;
  localparam logic [4:0] IDX_PER_CHANNEL_ERROR_LAST = 5'h0d;
  localparam logic [4:0] IDX_UNUSED_CHANNEL_ERROR_FIRST = 5'h0e;
  localparam logic [4:0] IDX_UNUSED_CHANNEL_ERROR_LAST = 5'h11;
  localparam logic [4:0] IDX_DIAG_TIMESTAMP = 5'h12;
  localparam logic [4:0] IDX_DIAG_TIMESTAMP_LAST = 5'h15;
  // ************************************************************
  // Constant contents and field positions
  // ************************************************************
  localparam logic [7:0] DIAG_BITS_PER_CHANNEL = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT = 8'h04;
  localparam int CH_ERR_PARAM_BIT = 0;
  localparam int CH_ERR_SHORT_BIT = 3;
  localparam int MODULE_CHANNEL_ERROR_BIT = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_TICKER = 32'h0000_0000;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int TICK_NS = 1000;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  // Per-channel raw fault inputs
  typedef struct packed {
    logic param_err;
    logic short_gnd;
  } chan_fault_s;
endpackage : diag_record_pkg
`default_nettype wire

/* File: logic/us_ticker.sv */
/*
  Free-running 32-bit microsecond ticker.
  Assumes sys_clk at the rate in diag_record_pkg; synchronous active-low reset
  stands for power-on.
*/
`timescale 1ns/1ps
`default_nettype none
module us_ticker #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic [WIDTH-1:0] ticks_q
);
  localparam int PRE_W = $clog2(diag_record_pkg::TICK_CYCLES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(diag_record_pkg::TICK_CYCLES - 1);
  logic [PRE_W-1:0] pre_q;

  // Prescaler from clock cycles to microseconds
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pre_q <= '0;
    end else if (pre_q == PRE_LAST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Ticker counts from zero and wraps at all ones
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ticks_q <= '0;
    end else if (pre_q == PRE_LAST) begin
      ticks_q <= ticks_q + 1'b1;
    end
  end
endmodule : us_ticker
`default_nettype wire
